//--- csr_bank_consts.vh
// Purpose: offsets, field positions and write masks of the general control/status bank
// Assumes: APB byte addresses, one 32-bit word per 16-bit register
// Notes: definitions only
`ifndef CSR_BANK_CONSTS_VH
`define CSR_BANK_CONSTS_VH
// register byte offsets (each register on a 32-byte line)
`define OFF_GENERAL_CONTROL 12'h000
`define OFF_ERROR_DIAG_STATUS 12'h040
`define OFF_TAG_COMPARE_ENABLE 12'h060
`define OFF_ERROR_ADDRESS_LOW 12'h080
`define OFF_ERROR_ADDRESS_HIGH 12'h0A0
`define OFF_LOCKED_ADDRESS_LOW 12'h0C0
`define OFF_LOCKED_ADDRESS_HIGH 12'h0E0
// general control fields
`define GC_ARB_LO 1
`define GC_WIDTH_BIT 4
`define GC_CACHE_EN 5
`define GC_NO_ALLOC 6
`define GC_LONG_WR 7
`define GC_IGN_TAG 8
`define GC_FRC_TAG 9
`define GC_FRC_D 10
`define GC_FRC_V 11
`define GC_FRC_P 12
`define GC_BAD_AP 13
// writable mask of general control (bits 13:5 and 2:1)
`define GC_WMASK 16'h3FE6
// error status fields
`define ES_MULTI 0
`define ES_TAP 1
`define ES_TCP 2
`define ES_NXM 3
`define ES_DMA 4
`define ES_VIC 5
`define ES_CREQ_LO 6
`define ES_VERSION 13
`define ES_LOCK 14
`define ES_WRITE_PENDING 15
// version bit reads high
`define VERSION_VALUE 1'h1
// tag compare mask: bits 15:1 writable
`define TAG_WMASK 16'hFFFE
`endif

//--- sync2.v
// Purpose: two-flop synchroniser for one pin level
// Assumes: single core clock
// Notes: first flop feeds only the second
module sync2 (
   // clock and reset
   input wire core_clk,
   input wire rst_n,
   // level in and out
   input wire pinIn,
   output reg pinSync
);
reg stage_reg;
// two-stage capture
always @(posedge core_clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      stage_reg <= 1'h0;
      pinSync <= 1'h0;
   end
   else
   begin
      stage_reg <= pinIn;
      pinSync <= stage_reg;
   end
end
endmodule // sync2

//--- error_logger.v
// Purpose: error flags, address lock and cause capture
// Assumes: error events are single-cycle pulses on the core clock
// Notes: hardware set wins over software clear
`include "csr_bank_consts.vh"
module error_logger (
   // clock and reset
   input wire core_clk,
   input wire rst_n,
   // error events
   input wire tagAddrParityErr,
   input wire tagCtrlParityErr,
   input wire nonexistent_memory_error,
   input wire errDma,
   input wire errVictim,
   input wire [2:0] errCpuReq,
   input wire [2:0] errIoCmd,
   input wire [33:5] errAddr,
   // software write-one-to-clear
   input wire clrStrobe,
   input wire [3:0] clrBits,
   // captured state
   output reg [3:0] errFlags,
   output reg dmaOrigin,
   output reg victimOrigin,
   output reg [2:0] causeReq,
   output reg [28:0] lockedErrAddr
);
wire anyErr = tagAddrParityErr | tagCtrlParityErr | nonexistent_memory_error;
wire locked = |errFlags[3:1];
wire [3:0] clr = clrStrobe ? clrBits : 4'h0;
// flags and lock capture
always @(posedge core_clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      errFlags <= 4'h0;
      dmaOrigin <= 1'h0;
      victimOrigin <= 1'h0;
      causeReq <= 3'h0;
      lockedErrAddr <= 29'h0;
   end
   else
   begin
      if (anyErr && !locked)
      begin
         errFlags[3:1] <= {nonexistent_memory_error, tagCtrlParityErr, tagAddrParityErr} | (errFlags[3:1] & ~clr[3:1]);
         errFlags[0] <= errFlags[0] & ~clr[0];
         dmaOrigin <= errDma;
         victimOrigin <= errVictim & nonexistent_memory_error;
         causeReq <= errDma ? errIoCmd : errCpuReq;
         lockedErrAddr <= errAddr;
      end
      else if (anyErr)
      begin
         errFlags[3:1] <= errFlags[3:1] & ~clr[3:1];
         errFlags[0] <= 1'h1;
      end
      else
         errFlags <= errFlags & ~clr;
   end
end
endmodule // error_logger

//--- cache_mem_ctrl_general_csrs.v
// Purpose: general control and status registers of a cache and memory controller
// Assumes: APB slave on core_clk (40 MHz), one 32-bit word per 16-bit register
// Notes: steering outputs are registered copies of control and tag mask fields
//    unmapped words answer with pslverr and read as zero
//    any apb write, mapped or not, drops the load-locked flag
//    error flags follow set-wins-over-clear ordering
//
// Added by the designer: the APB register port and the register offsets.
`include "csr_bank_consts.vh"
module cache_mem_ctrl_general_csrs (
   // clock and reset
   input wire core_clk,
   input wire rst_n,
   // apb request
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   // apb answer
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // pins
   input wire memoryWidthPin,
   // load-locked and write buffer tracking
   input wire loadLockedStrobe,
   input wire [33:5] loadLockedAddr,
   input wire ioSpaceWrite,
   input wire writeBufferValid,
   // error events
   input wire tagAddrParityErr,
   input wire tagCtrlParityErr,
   input wire nonexistent_memory_error,
   // error cause, sampled with the error pulse
   input wire errDma,
   input wire errVictim,
   input wire [2:0] errCpuReq,
   input wire [2:0] errIoCmd,
   input wire [33:5] errAddr,
   // tag compare
   input wire [31:17] tagAddressBits,
   input wire [31:17] systemAddress,
   output reg tagMatch,
   // arbitration mode
   output reg [1:0] arbitrationSelect,
   output reg dmaPriority,
   output reg strongDmaPriority,
   // cache probe and write modes
   output reg probeEnable,
   output reg allocateOnWrite,
   output reg [1:0] cacheWriteCycles,
   // tag diagnostics
   output reg forceMiss,
   output reg discardVictim,
   output reg checkTagParity,
   output reg forceTagWrite,
   output reg [2:0] fillTagControl,
   output reg fillCacheable,
   output reg badAddressParity
);

////////////////////////////////////////////////////////////////////////////////
// registers and wires
// software-visible storage
reg [15:0] general_control_reg;
reg [15:0] tag_compare_mask_reg;
reg [28:0] locked_address_reg;
reg load_locked_flag_reg;
reg write_pending_reg;
// combinational next values
reg [31:0] rdata_next;
reg [1:0] cacheWriteCycles_next;
reg [2:0] fillTagControl_next;
reg [15:1] tagDiff;
// synchronised pin and logged error state
wire memWidthSync;
wire [3:0] errFlags;
wire dmaOrigin;
wire victimOrigin;
wire [2:0] causeReq;
wire [28:0] lockedErrAddr;
// apb decode: an access is taken in its first access cycle only
wire access = psel & penable & ~pready;
wire wrAccess = access & pwrite;
wire mapped = isMapped(paddr);
// per-register write strobes
wire wrControl = wrAccess & (paddr == `OFF_GENERAL_CONTROL);
wire wrStatus = wrAccess & (paddr == `OFF_ERROR_DIAG_STATUS);
wire wrTagMask = wrAccess & (paddr == `OFF_TAG_COMPARE_ENABLE);

// address decode for the pslverr error path; write strobes and read mux compare offsets directly
function isMapped;
   input [11:0] a;
   begin
      isMapped = (a == `OFF_GENERAL_CONTROL) || (a == `OFF_ERROR_DIAG_STATUS) ||
         (a == `OFF_TAG_COMPARE_ENABLE) || (a == `OFF_ERROR_ADDRESS_LOW) ||
         (a == `OFF_ERROR_ADDRESS_HIGH) || (a == `OFF_LOCKED_ADDRESS_LOW) ||
         (a == `OFF_LOCKED_ADDRESS_HIGH);
   end
endfunction

// low half of a captured address (system address 20:5)
function [15:0] lowHalf;
   input [28:0] a;
   begin
      lowHalf = a[15:0];
   end
endfunction

// high half of a captured address (system address 33:21 in bits 12:0)
function [15:0] highHalf;
   input [28:0] a;
   begin
      highHalf = {3'h0, a[28:16]};
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// submodules
sync2 u_width_sync (
   .core_clk(core_clk),
   .rst_n(rst_n),
   .pinIn(memoryWidthPin),
   .pinSync(memWidthSync)
);

error_logger u_err (
   .core_clk(core_clk),
   .rst_n(rst_n),
   .tagAddrParityErr(tagAddrParityErr),
   .tagCtrlParityErr(tagCtrlParityErr),
   .nonexistent_memory_error(nonexistent_memory_error),
   .errDma(errDma),
   .errVictim(errVictim),
   .errCpuReq(errCpuReq),
   .errIoCmd(errIoCmd),
   .errAddr(errAddr),
   .clrStrobe(wrStatus),
   .clrBits(pwdata[3:0]),
   .errFlags(errFlags),
   .dmaOrigin(dmaOrigin),
   .victimOrigin(victimOrigin),
   .causeReq(causeReq),
   .lockedErrAddr(lockedErrAddr)
);

////////////////////////////////////////////////////////////////////////////////
// read mux
always @*
begin
   rdata_next = 32'h0;
   case (paddr)
      `OFF_GENERAL_CONTROL:
      begin
         rdata_next[15:0] = general_control_reg;
         rdata_next[`GC_WIDTH_BIT] = memWidthSync;
      end
      `OFF_ERROR_DIAG_STATUS:
      begin
         rdata_next[3:0] = errFlags;
         rdata_next[`ES_DMA] = dmaOrigin;
         rdata_next[`ES_VIC] = victimOrigin;
         rdata_next[`ES_CREQ_LO + 2:`ES_CREQ_LO] = causeReq;
         rdata_next[`ES_VERSION] = `VERSION_VALUE;
         rdata_next[`ES_LOCK] = load_locked_flag_reg;
         rdata_next[`ES_WRITE_PENDING] = write_pending_reg;
      end
      `OFF_TAG_COMPARE_ENABLE:
         rdata_next[15:0] = tag_compare_mask_reg;
      `OFF_ERROR_ADDRESS_LOW:
         rdata_next[15:0] = lowHalf(lockedErrAddr);
      `OFF_ERROR_ADDRESS_HIGH:
         rdata_next[15:0] = highHalf(lockedErrAddr);
      `OFF_LOCKED_ADDRESS_LOW:
         rdata_next[15:0] = lowHalf(locked_address_reg);
      `OFF_LOCKED_ADDRESS_HIGH:
         rdata_next[15:0] = highHalf(locked_address_reg);
      default:
         rdata_next = 32'h0;
   endcase
end

////////////////////////////////////////////////////////////////////////////////
// apb handshake: one wait state, answer in second access cycle
always @(posedge core_clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      pready <= 1'h0;
      pslverr <= 1'h0;
      prdata <= 32'h0;
   end
   else
   begin
      // answer one cycle after the access is taken
      pready <= access;
      pslverr <= access & ~mapped;
      // read data captured once per read, then held
      if (access && !pwrite)
         prdata <= rdata_next;
   end
end

////////////////////////////////////////////////////////////////////////////////
// writable registers; read-only ones ignore writes
always @(posedge core_clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      general_control_reg <= 16'h0000;
      tag_compare_mask_reg <= 16'h0000;
   end
   else
   begin
      if (wrControl)
         general_control_reg <= pwdata[15:0] & `GC_WMASK;
      if (wrTagMask)
         tag_compare_mask_reg <= pwdata[15:0] & `TAG_WMASK;
   end
end

////////////////////////////////////////////////////////////////////////////////
// write buffer status, one cycle behind the buffer's valid level
always @(posedge core_clk or negedge rst_n)
begin
   if (!rst_n)
      write_pending_reg <= 1'h0;
   else
      write_pending_reg <= writeBufferValid;
end

// load-locked tracking: new load-locked sets, any write clears, set wins
always @(posedge core_clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      load_locked_flag_reg <= 1'h0;
      locked_address_reg <= 29'h0;
   end
   else
   begin
      if (loadLockedStrobe)
      begin
         load_locked_flag_reg <= 1'h1;
         locked_address_reg <= loadLockedAddr;
      end
      else if (wrAccess || ioSpaceWrite)
         load_locked_flag_reg <= 1'h0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// steering decode from control bits
always @*
begin
   cacheWriteCycles_next = general_control_reg[`GC_LONG_WR] ? 2'h2 : 2'h1;
   fillTagControl_next = {general_control_reg[`GC_FRC_P], general_control_reg[`GC_FRC_V],
      general_control_reg[`GC_FRC_D]};
end

// masked tag difference: a cleared mask bit skips that compare
always @*
begin
   tagDiff = (tagAddressBits ^ systemAddress) & tag_compare_mask_reg[15:1];
end

// registered arbitration and cache mode outputs
always @(posedge core_clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      arbitrationSelect <= 2'h0;
      dmaPriority <= 1'h0;
      strongDmaPriority <= 1'h0;
      probeEnable <= 1'h0;
      allocateOnWrite <= 1'h1;
      cacheWriteCycles <= 2'h1;
   end
   else
   begin
      arbitrationSelect <= general_control_reg[2:1];
      dmaPriority <= general_control_reg[2];
      strongDmaPriority <= general_control_reg[2] & general_control_reg[1];
      probeEnable <= general_control_reg[`GC_CACHE_EN];
      allocateOnWrite <= ~general_control_reg[`GC_NO_ALLOC];
      cacheWriteCycles <= cacheWriteCycles_next;
   end
end

// registered tag diagnostic outputs
always @(posedge core_clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      forceMiss <= 1'h0;
      discardVictim <= 1'h0;
      checkTagParity <= 1'h1;
      forceTagWrite <= 1'h0;
      fillTagControl <= 3'h0;
      fillCacheable <= 1'h0;
      badAddressParity <= 1'h0;
   end
   else
   begin
      forceMiss <= general_control_reg[`GC_IGN_TAG];
      discardVictim <= general_control_reg[`GC_IGN_TAG];
      checkTagParity <= ~general_control_reg[`GC_IGN_TAG];
      forceTagWrite <= general_control_reg[`GC_FRC_TAG];
      fillTagControl <= fillTagControl_next;
      fillCacheable <= general_control_reg[`GC_FRC_TAG];
      badAddressParity <= general_control_reg[`GC_BAD_AP];
   end
end

// registered tag compare result; ignore-tag forces a miss
always @(posedge core_clk or negedge rst_n)
begin
   if (!rst_n)
      tagMatch <= 1'h0;
   else
      tagMatch <= ~|tagDiff & ~general_control_reg[`GC_IGN_TAG];
end
endmodule // cache_mem_ctrl_general_csrs

//--- csr_bank_checker_properties.sv
// Purpose: port checks on the general csr bank
// Assumes: one clock domain, async active-low reset
// Notes: bound into every instance of the bank
module csr_bank_checker (
   // clock, reset and apb
   input wire logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr,
   input wire logic [31:0] prdata,
   // steering outputs
   input wire logic tagMatch, dmaPriority, strongDmaPriority, probeEnable, allocateOnWrite,
   input wire logic forceMiss, discardVictim, checkTagParity, forceTagWrite, fillCacheable,
   input wire logic badAddressParity,
   input wire logic [1:0] arbitrationSelect, cacheWriteCycles
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // a completed apb write
   wire wrDone = psel & penable & pwrite & pready;
   ////////////////////////////////////////////////////////////////////////////////
   // apb answer and steering relations
   AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb access not ended after one wait");
   AST_REFUSED_READ: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   AST_ARB_DMA: assert property (arbitrationSelect == 2'h2 |-> dmaPriority && !strongDmaPriority)
      else $error("dma priority mode wrong");
   AST_ARB_STRONG: assert property (arbitrationSelect == 2'h3 |-> strongDmaPriority)
      else $error("strong dma mode wrong");
   AST_ARB_CPU: assert property (!arbitrationSelect[1] |-> !dmaPriority && !strongDmaPriority)
      else $error("processor priority mode wrong");
   AST_PROBE_BY_WRITE: assert property ($rose(probeEnable) |-> $past(wrDone))
      else $error("probing enabled without a write");
   AST_ALLOC_BY_WRITE: assert property ($fell(allocateOnWrite) |-> $past(wrDone))
      else $error("allocation stopped without a write");
   AST_LONG_WRITE: assert property ($changed(cacheWriteCycles) |-> $past(wrDone))
      else $error("cache write length changed without a write");
   AST_IGNORE_TAG: assert property (forceMiss && $past(forceMiss)
      |-> !tagMatch && discardVictim && !checkTagParity)
      else $error("ignore-tag mode still matching");
   AST_FORCE_CACHEABLE: assert property (forceTagWrite |-> fillCacheable)
      else $error("forced fill not cacheable");
   AST_BAD_PARITY: assert property ($changed(badAddressParity) |-> $past(wrDone))
      else $error("bad parity mode changed without a write");
   // main scenarios
   cover property (wrDone && pslverr);
   cover property (tagMatch);
   cover property (forceMiss && forceTagWrite);
endmodule // csr_bank_checker

bind cache_mem_ctrl_general_csrs csr_bank_checker checker_i (.*);

//--- sys_bus_agent.sv
// Purpose: system bus side raising error and load-locked events
// Assumes: tasks called right after a rising edge
// Notes: cause lines carry inverted values outside a pulse
module sys_bus_agent (
   // clock
   input wire logic core_clk,
   // events and causes
   output logic tagAddrParityErr, tagCtrlParityErr, nonexistent_memory_error, loadLockedStrobe, ioSpaceWrite,
   output logic errDma, errVictim,
   output logic [2:0] errCpuReq, errIoCmd,
   output logic [28:0] errAddr, loadLockedAddr
);
   timeunit 1ns;
   timeprecision 1ps;
   // quiet at time zero
   initial
   begin
      {tagAddrParityErr, tagCtrlParityErr, nonexistent_memory_error, loadLockedStrobe, ioSpaceWrite} = 5'h00;
      {errDma, errVictim, errCpuReq, errIoCmd, errAddr, loadLockedAddr} = 66'h0;
   end
   // one-cycle error; k is nxm, tag control, tag address
   task err(input logic [2:0] k, input logic d, v, input logic [2:0] q, io, input logic [28:0] a);
      {nonexistent_memory_error, tagCtrlParityErr, tagAddrParityErr} <= k;
      {errDma, errVictim, errCpuReq, errIoCmd, errAddr} <= {d, v, q, io, a};
      @(posedge core_clk);
      {nonexistent_memory_error, tagCtrlParityErr, tagAddrParityErr} <= 3'h0;
      {errDma, errVictim, errCpuReq, errIoCmd, errAddr} <= ~{d, v, q, io, a};
   endtask
   // processor load-locked transaction
   task ll(input logic [28:0] a);
      loadLockedStrobe <= 1'h1;
      loadLockedAddr <= a;
      @(posedge core_clk);
      loadLockedStrobe <= 1'h0;
      loadLockedAddr <= ~a;
   endtask
   // one i/o space write
   task iow();
      ioSpaceWrite <= 1'h1;
      @(posedge core_clk);
      ioSpaceWrite <= 1'h0;
   endtask
endmodule // sys_bus_agent

//--- cache_mem_ctrl_general_csrs_bench.sv
// Purpose: self-checking bench for the general csr bank
// Assumes: 40 MHz core clock, apb master here
// Notes: bus events come from sys_bus_agent
`include "csr_bank_consts.vh"
module cache_mem_ctrl_general_csrs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // compare and count
`define CHK(n, e, g) \
   begin \
      checked++; \
      if ((g) !== (e)) \
      begin \
         mismatches++; \
         $display("unexpected %s: expected %h seen %h", n, e, g); \
      end \
   end
   localparam logic [11:0] CT = `OFF_GENERAL_CONTROL, ST = `OFF_ERROR_DIAG_STATUS;
   localparam logic [11:0] TM = `OFF_TAG_COMPARE_ENABLE, EL = `OFF_ERROR_ADDRESS_LOW;
   localparam logic [28:0] ADDR1 = 29'h12345678, ADDR2 = 29'h0ABCDEF1;
   logic core_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic memoryWidthPin = 1'h0, writeBufferValid = 1'h0;
   logic [14:0] tagAddressBits = 15'h0, systemAddress = 15'h0;
   wire [31:0] prdata;
   wire pready, pslverr, tagMatch, dmaPriority, strongDmaPriority, probeEnable, allocateOnWrite;
   wire forceMiss, discardVictim, checkTagParity, forceTagWrite, fillCacheable, badAddressParity;
   wire [1:0] arbitrationSelect, cacheWriteCycles;
   wire [2:0] fillTagControl, errCpuReq, errIoCmd;
   wire tagAddrParityErr, tagCtrlParityErr, nonexistent_memory_error, loadLockedStrobe, ioSpaceWrite, errDma, errVictim;
   wire [28:0] errAddr, loadLockedAddr;
   int mismatches = 0, checked = 0;
   cache_mem_ctrl_general_csrs dut (.*);
   sys_bus_agent agent (.*);
   // 25 ns clock
   always #12.5 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////////////////////
   // one apb transfer, held until pready
   task apb(input logic w, input logic [11:0] a, input logic [15:0] d, output logic [31:0] r,
      output logic e);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge core_clk);
      penable <= 1'h1;
      // wait for the answer; only the watchdog ends a hang
      do
         @(posedge core_clk);
      while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      // idle edge so a following call never re-drives psel in this step
      @(posedge core_clk);
   endtask
   task wr(input logic [11:0] a, input logic [15:0] d);
      logic [31:0] r;
      logic e;
      apb(1'h1, a, d, r, e);
   endtask
   // read and compare the masked bits
   task rdc(input string n, input logic [11:0] a, input logic [15:0] m, input logic [15:0] x);
      logic [31:0] r;
      logic e;
      apb(1'h0, a, 16'h0000, r, e);
      `CHK(n, {1'h0, 16'h0000, x & m}, {e, r & {16'hFFFF, m}});
   endtask
   task rdAddr(input string n, input logic [11:0] a, input logic [28:0] x);
      rdc(n, a, 16'hFFFF, x[15:0]);
      rdc(n, a + 12'h020, 16'hFFFF, {3'h0, x[28:16]});
   endtask
   task tick(input int c);
      repeat (c) @(posedge core_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // reset values, and the hole at 0x020 refused
   task resetValues();
      logic [31:0] r;
      logic e;
      for (int i = 0; i < 8; i++)
      begin
         apb(1'h0, 12'(i * 32), 16'h0000, r, e);
         `CHK("rst", {i == 1, 16'h0, i == 2 ? 16'h2000 : 16'h0}, {e, r});
      end
   endtask
   // all fields at once, then each arbitration mode and fill tag bit alone
   task controlModes();
      wr(CT, 16'h3FE6);
      tick(2);
      `CHK("steer", {2'h3, 9'h1B7, 2'h2, 3'h7},
         {arbitrationSelect, strongDmaPriority, probeEnable, allocateOnWrite, forceMiss,
          discardVictim, checkTagParity, forceTagWrite, fillCacheable, badAddressParity,
          cacheWriteCycles, fillTagControl});
      rdc("ctl", CT, 16'hFFFF, 16'h3FE6);
      memoryWidthPin <= 1'h1;
      tick(3);
      rdc("width", CT, 16'h0010, 16'h0010);
      for (int a = 0; a < 4; a++)
      begin
         wr(CT, {13'h0, a[1:0], 1'h0});
         tick(2);
         `CHK("arb", {a[1:0], a == 3}, {arbitrationSelect, strongDmaPriority});
         if (a == 2)
            `CHK("dma", 1'h1, dmaPriority);
      end
      for (int i = 0; i < 3; i++)
      begin
         wr(CT, 16'h0400 << i);
         tick(2);
         `CHK("fill", 3'h1 << i, fillTagControl);
      end
      wr(CT, 16'h0000);
      tick(2);
      `CHK("idle", {3'h2, 2'h1},
         {probeEnable, allocateOnWrite, forceMiss, cacheWriteCycles});
   endtask
   // mask from cache size and memory size; one skipped, one compared bit
   task tagCompare();
      wr(TM, 16'hFF00 & 16'h3FFE);
      rdc("mask", TM, 16'hFFFF, 16'h3F00);
      systemAddress <= 15'h4000;
      tick(2);
      `CHK("skip", 1'h1, tagMatch);
      systemAddress <= 15'h0080;
      tick(2);
      `CHK("cmp", 1'h0, tagMatch);
   endtask
   // first error locks, later ones set the multiple-error bit, unlock on all three clear
   task errorLogging();
      agent.err(3'h1, 1'h0, 1'h0, 3'h5, 3'h2, ADDR1);
      rdc("st1", ST, 16'hFFFF, 16'h2142);
      rdAddr("ea1", EL, ADDR1);
      agent.err(3'h4, 1'h1, 1'h1, 3'h1, 3'h6, ADDR2);
      rdc("st2", ST, 16'hFFFF, 16'h2143);
      rdAddr("ea2", EL, ADDR1);
      wr(ST, 16'h0001);
      rdc("st3", ST, 16'hFFFF, 16'h2142);
      agent.err(3'h2, 1'h0, 1'h0, 3'h0, 3'h0, ADDR2);
      rdc("st4", ST, 16'hFFFF, 16'h2143);
      wr(ST, 16'h0003);
      agent.err(3'h4, 1'h1, 1'h1, 3'h1, 3'h6, ADDR2);
      rdc("st5", ST, 16'hFFFF, 16'h21B8);
      rdAddr("ea3", EL, ADDR2);
      wr(ST, 16'h0008);
      agent.err(3'h2, 1'h0, 1'h1, 3'h7, 3'h0, ADDR1);
      rdc("st6", ST, 16'hFFFF, 16'h21C4);
   endtask
   // lock flag set by the agent, cleared by register or i/o writes
   task loadLocked();
      agent.ll(ADDR2);
      rdc("ll1", ST, 16'h4000, 16'h4000);
      rdAddr("la1", `OFF_LOCKED_ADDRESS_LOW, ADDR2);
      wr(TM, 16'h3F00);
      rdc("ll2", ST, 16'h4000, 16'h0000);
      agent.ll(ADDR1);
      agent.iow();
      rdc("ll3", ST, 16'h4000, 16'h0000);
      rdAddr("la2", `OFF_LOCKED_ADDRESS_LOW, ADDR1);
      writeBufferValid <= 1'h1;
      tick(2);
      rdc("wp", ST, 16'h8000, 16'h8000);
   endtask
   task conclude();
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // reset for 12 cycles, then the scenarios
   initial
   begin
      tick(12);
      rst_n <= 1'h1;
      tick(1);
      resetValues();
      controlModes();
      tagCompare();
      errorLogging();
      loadLocked();
      conclude();
   end
   // hang guard
   initial
   begin
      tick(5000);
      mismatches++;
      conclude();
   end
endmodule // cache_mem_ctrl_general_csrs_bench
